// ---- rtl/video_pattern_wb_dither.sv ----
// Pattern generator, white balance tables and two-stage dithering for the pixel path.
// Assumes pixel clock at clk, inputs synchronous, power-down mapped onto rst_n.
`timescale 1ns/1ps
`default_nettype none

module video_pattern_wb_dither
  import video_pattern_wb_dither_pkg::*;
#(
  parameter int LUT_AW = 8 // Table address width
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire rgb_t       pix_in,
  input  wire sync_t      sync_in,
  input  wire patcfg_t    patgen_config_reg,
  input  wire rgb_t       patgen_custom_colour,
  input  wire timing_t    int_timing,
  input  wire logic       osc_bit_set,
  input  wire logic [3:0] patgen_indirect_index,
  input  wire logic [7:0] patgen_indirect_value,
  input  wire logic       ind_wr,
  input  wire logic [3:0] slot_addr,
  input  wire logic [4:0] slot_value,
  input  wire logic       slot_wr,
  input  wire enhcfg_t    enh_cfg,
  input  wire logic [1:0] lut_page,
  input  wire logic [7:0] lut_addr,
  input  wire logic [7:0] lut_wdata,
  input  wire logic       lut_wr,
  output logic [7:0]      lut_rdata,
  output logic            lut_wr_rejected,
  output logic            osc_required,
  output rgb_t            pix_out,
  output sync_t           sync_out
);

  // Delay line and detected edges
  sync_t sync_d1_r;
  sync_t sync_d2_r;
  logic  de_prev_r;
  logic  vs_prev_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_d1_r <= '0;
      sync_d2_r <= '0;
      de_prev_r <= 1'b0;
      vs_prev_r <= 1'b0;
    end else begin
      sync_d1_r <= sync_in;   // [RULE_07]
      sync_d2_r <= sync_d1_r; // [RULE_07]
      de_prev_r <= sync_in.de;
      vs_prev_r <= sync_in.vs;
    end
  end

  // Measured frame size in external timing
  logic [11:0] hcnt_r;
  logic [11:0] vcnt_r;
  logic [11:0] width_r;
  logic [11:0] height_r;
  logic [12:0] idle_r;
  logic        ext_vblank;
  logic        ext_frame_end;
  assign ext_vblank    = ({1'b0, idle_r} > {width_r, 1'b0}); // [RULE_05]
  assign ext_frame_end = (sync_in.vs && !vs_prev_r) || (idle_r == {width_r, 1'b0} + 13'h1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_r   <= TIMING_RESET;
      vcnt_r   <= TIMING_RESET;
      width_r  <= TIMING_RESET;
      height_r <= TIMING_RESET;
      idle_r   <= '0;
    end else begin
      if (sync_in.de) begin
        hcnt_r <= hcnt_r + 12'h1;
        idle_r <= '0;
      end else begin
        if (idle_r != 13'h1fff) idle_r <= idle_r + 13'h1;
        if (de_prev_r) begin
          width_r <= hcnt_r; // [RULE_08]
          hcnt_r  <= TIMING_RESET;
          vcnt_r  <= vcnt_r + 12'h1;
        end
      end
      if (ext_frame_end && vcnt_r != TIMING_RESET) begin
        height_r <= vcnt_r; // [RULE_08]
        vcnt_r   <= TIMING_RESET;
      end
    end
  end

  // Internal timing raster
  logic [11:0] ih_r;
  logic [11:0] iv_r;
  sync_t       int_sync;
  assign int_sync.de = (ih_r < int_timing.h_active) && (iv_r < int_timing.v_active); // [RULE_06]
  assign int_sync.hs = (ih_r >= int_timing.h_active);
  assign int_sync.vs = (iv_r >= int_timing.v_active);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ih_r <= TIMING_RESET;
      iv_r <= TIMING_RESET;
    end else if (ih_r + 12'h1 >= int_timing.h_total) begin
      ih_r <= TIMING_RESET;
      iv_r <= (iv_r + 12'h1 >= int_timing.v_total) ? TIMING_RESET : iv_r + 12'h1;
    end else begin
      ih_r <= ih_r + 12'h1;
    end
  end

  // Chosen raster: position and size
  sync_t       raster;
  logic [11:0] xpos;
  logic [11:0] ypos;
  logic [11:0] fw;
  logic [11:0] fh;
  assign raster = patgen_config_reg.int_timing ? int_sync : sync_d2_r;
  assign xpos   = patgen_config_reg.int_timing ? ih_r : hcnt_r;
  assign ypos   = patgen_config_reg.int_timing ? iv_r : vcnt_r;
  assign fw     = patgen_config_reg.int_timing ? int_timing.h_active : width_r;
  assign fh     = patgen_config_reg.int_timing ? int_timing.v_active : height_r;

  // Frame start pulse for scroll and dither counters
  logic frame_tick;
  assign frame_tick = patgen_config_reg.int_timing ?
                      (ih_r == TIMING_RESET && iv_r == TIMING_RESET) : ext_frame_end;

  // Indirect settings and scroll slot table
  logic [3:0] scroll_last_r;
  logic [7:0] scroll_time_r;
  logic       chk_custom_r;
  logic       vcom_vert_r;
  logic [4:0] slots_r [SCROLL_SLOTS];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scroll_last_r <= 4'hf;
      scroll_time_r <= SCROLL_FRAMES;
      chk_custom_r  <= 1'b0;
      vcom_vert_r   <= 1'b0;
      for (int i = 0; i < SCROLL_SLOTS; i++) slots_r[i] <= PAT_WHITE;
    end else begin
      if (ind_wr) begin
        case (patgen_indirect_index) // [RULE_11]
          IDX_SCROLL_N: scroll_last_r <= patgen_indirect_value[3:0];
          IDX_SCROLL_T: scroll_time_r <= patgen_indirect_value;
          IDX_CHK_COL:  chk_custom_r  <= patgen_indirect_value[0];
          IDX_VCOM_DIR: vcom_vert_r   <= patgen_indirect_value[0];
          default:      ; // Unused indices ignored
        endcase
      end
      if (slot_wr) slots_r[slot_addr] <= slot_value; // [RULE_10] repeats allowed
    end
  end

  // Auto-scroll stepping
  logic [3:0] slot_r;
  logic [7:0] dwell_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_r  <= 4'h0;
      dwell_r <= 8'h00;
    end else if (!patgen_config_reg.auto_scroll) begin
      slot_r  <= 4'h0;
      dwell_r <= 8'h00;
    end else if (frame_tick) begin
      if (dwell_r >= scroll_time_r) begin
        dwell_r <= 8'h00;
        slot_r  <= (slot_r >= scroll_last_r) ? 4'h0 : slot_r + 4'h1; // [RULE_10]
      end else begin
        dwell_r <= dwell_r + 8'h01;
      end
    end
  end

  // Bars never entered while scrolling; substitute white
  logic [4:0] pat_sel;
  always_comb begin
    pat_sel = patgen_config_reg.auto_scroll ? slots_r[slot_r] : patgen_config_reg.pattern;
    if (patgen_config_reg.auto_scroll && pat_sel >= PAT_BARS) pat_sel = PAT_WHITE; // [RULE_03]
  end

  // Scaled ramp: position over size mapped to 0..255
  function automatic logic [7:0] ramp(input logic [11:0] pos, input logic [11:0] size);
    logic [19:0] num;
    num = {pos, 8'h00};
    if (size == 12'h000) ramp = pos[7:0];
    else ramp = (num / {8'h00, size} > 20'hff) ? 8'hff : 8'(num / {8'h00, size});
  endfunction

  // Colour mask from a three-bit r/g/b selector
  function automatic rgb_t tint(input logic [2:0] m, input logic [7:0] v);
    tint = '{r: m[2] ? v : 8'h00, g: m[1] ? v : 8'h00, b: m[0] ? v : 8'h00};
  endfunction

  // Pattern colour
  rgb_t pat_pix;
  logic [7:0] hr;
  logic [7:0] vr;
  logic [2:0] grad_mask; // Gradient tint; codes 05 and 09 are grey ramps
  always_comb begin
    hr  = ramp(xpos, fw); // [RULE_08]
    vr  = ramp(ypos, fh);
    grad_mask = (pat_sel[1:0] == 2'h1) ? 3'h7 : 3'h4 >> (pat_sel[1:0] - 2'h2);
    case (pat_sel) // [RULE_02]
      PAT_WHITE:   pat_pix = tint(3'h7, 8'hff);
      PAT_BLACK:   pat_pix = tint(3'h0, 8'hff);
      PAT_RED:     pat_pix = tint(3'h4, 8'hff);
      PAT_GREEN:   pat_pix = tint(3'h2, 8'hff);
      PAT_BLUE:    pat_pix = tint(3'h1, 8'hff);
      5'h05, 5'h06, 5'h07, 5'h08: pat_pix = tint(grad_mask, hr);
      5'h09, 5'h0a, 5'h0b, 5'h0c: pat_pix = tint(grad_mask, vr);
      PAT_CUSTOM:  pat_pix = patgen_custom_colour;
      PAT_CHECKER: pat_pix = (xpos[5] ^ ypos[5]) ? (chk_custom_r ? patgen_custom_colour :
                             tint(3'h7, 8'hff)) : tint(3'h0, 8'hff);
      PAT_VCOM:    pat_pix = tint((vcom_vert_r ? ypos[1:0] : xpos[1:0]) == 2'h0 ? 3'h6 :
                             (vcom_vert_r ? ypos[1:0] : xpos[1:0]) == 2'h1 ? 3'h3 :
                             (vcom_vert_r ? ypos[1:0] : xpos[1:0]) == 2'h2 ? 3'h5 : 3'h1,
                             8'hff);
      PAT_BARS:    pat_pix = tint(~{hr[6], hr[7], hr[5]}, 8'hff); // Eighth of width picks bar
      default:     pat_pix = tint(3'h0, 8'hff);
    endcase
    if (patgen_config_reg.invert) pat_pix = ~pat_pix; // [RULE_09]
    if (patgen_config_reg.depth18) begin // [RULE_04]
      pat_pix.r[1:0] = LOW_BITS_ZERO;
      pat_pix.g[1:0] = LOW_BITS_ZERO;
      pat_pix.b[1:0] = LOW_BITS_ZERO;
    end
  end

  // Frame and line counters for dither indexing
  logic [1:0] dfrm_r;
  logic [1:0] dline_r;
  logic [2:0] dpix_r;
  logic       rde_prev_r; // Own history; the input's is another stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dfrm_r     <= 2'h0;
      dline_r    <= 2'h0;
      dpix_r     <= 3'h0;
      rde_prev_r <= 1'b0;
    end else begin
      if (frame_tick) begin // [RULE_23]
        dfrm_r  <= dfrm_r + 2'h1;
        dline_r <= 2'h0;
      end else if (!raster.de && rde_prev_r) begin
        dline_r <= dline_r + 2'h1; // [RULE_23]
      end
      dpix_r     <= raster.de ? dpix_r + 3'h1 : 3'h0;
      rde_prev_r <= raster.de;
    end
  end

  // Nine-bit dither of one colour to six bits, low bits zero
  function automatic logic [7:0] dither(input logic [7:0] v, input logic [1:0] f,
                                        input logic [1:0] l, input logic [2:0] p);
    logic [8:0] e;
    logic [2:0] lsb;
    logic       add;
    logic [6:0] up;
    e   = {v, v[7]}; // [RULE_21]
    lsb = e[2:0];
    add = 1'b0;
    if (v == 8'h00 || v == 8'hff) add = 1'b0;           // [RULE_21] full off / on
    else if (v[7:2] == 6'h3f) add = 1'b0;               // [RULE_21] near full, no overflow
    else if (lsb == 3'h0) add = 1'b0;                   // [RULE_21] exact level
    else add = ({1'b0, p + {f, 1'b0} + {l, 1'b0} + l} % 4'h8) < {1'b0, lsb}; // [RULE_22]
    up = {1'b0, v[7:2]} + {6'h00, add};                 // [RULE_22]
    dither = {up[5:0], LOW_BITS_ZERO};                  // [RULE_18]
  endfunction

  // Stage one: generator or video, then pre-table dither
  rgb_t src;
  rgb_t st1;
  always_comb begin
    src = patgen_config_reg.enable ? pat_pix : pix_in; // [RULE_01]
    st1 = src;
    if (enh_cfg.dither1) begin // [RULE_19]
      st1.r = dither(src.r, dfrm_r, dline_r, dpix_r);
      st1.g = dither(src.g, dfrm_r, dline_r, dpix_r);
      st1.b = dither(src.b, dfrm_r, dline_r, dpix_r);
    end
  end

  // Colour tables and load sequencing
  logic [7:0] lut_r [3][LUT_DEPTH];
  load_t      load_r;
  logic       wr_ok;
  assign wr_ok = lut_wr && lut_page != 2'h3 &&
                 (load_r != LOAD_DONE ? lut_page == 2'(load_r) : enh_cfg.wb_reload); // [RULE_16]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_r <= LOAD_RED;
      for (int c = 0; c < 3; c++)
        for (int i = 0; i < LUT_DEPTH; i++) lut_r[c][i] <= LUT_RESET;
    end else if (wr_ok) begin
      lut_r[lut_page][lut_addr] <= lut_wdata; // [RULE_12] [RULE_17] single-entry update
      if (load_r != LOAD_DONE && lut_addr == 8'hff) begin
        case (load_r) // [RULE_15] red, green, blue order
          LOAD_RED:   load_r <= LOAD_GREEN;
          LOAD_GREEN: load_r <= LOAD_BLUE;
          LOAD_BLUE:  load_r <= LOAD_DONE;
          default:    load_r <= LOAD_DONE;
        endcase
      end
    end
  end

  // Table lookup then post-table dither
  rgb_t st2;
  rgb_t st3;
  always_comb begin
    st2 = st1;
    if (enh_cfg.wb_enable) begin // [RULE_12]
      st2.r = lut_r[0][st1.r];
      st2.g = lut_r[1][st1.g];
      st2.b = lut_r[2][st1.b];
    end
    st3 = st2;
    if (enh_cfg.dither2) begin // [RULE_14] [RULE_19]
      st3.r = dither(st2.r, dfrm_r, dline_r, dpix_r);
      st3.g = dither(st2.g, dfrm_r, dline_r, dpix_r);
      st3.b = dither(st2.b, dfrm_r, dline_r, dpix_r);
    end
  end

  // Registered outputs; external sync keeps its two-clock delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_out         <= '0;
      sync_out        <= '0;
      lut_rdata       <= 8'h00;
      lut_wr_rejected <= 1'b0;
      osc_required    <= 1'b0;
    end else begin
      pix_out         <= st3;
      sync_out        <= patgen_config_reg.int_timing ? int_sync : sync_d1_r; // [RULE_07]
      lut_rdata       <= (lut_page == 2'h3) ? 8'h00 : lut_r[lut_page][lut_addr];
      lut_wr_rejected <= lut_wr && !wr_ok; // [RULE_16]
      osc_required    <= patgen_config_reg.int_clock && !osc_bit_set; // [RULE_06]
    end
  end

  // Checks
  a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
    !patgen_config_reg.int_timing ##1 !patgen_config_reg.int_timing |->
    sync_out == $past(sync_in, 2)) else $error("sync not delayed by two");
  a_low_bits_dither: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_18]
    enh_cfg.dither2 |=> pix_out.r[1:0] == 2'h0 && pix_out.b[1:0] == 2'h0)
    else $error("dither low bits active");
  a_no_bars_scroll: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
    patgen_config_reg.auto_scroll |-> pat_sel != PAT_BARS) else $error("bars in scroll");
  a_reject_rewrite: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
    lut_wr && load_r == LOAD_DONE && !enh_cfg.wb_reload |=> lut_wr_rejected)
    else $error("rewrite accepted");
  sequence s_entry_held; // Write, then the same entry still addressed
    wr_ok ##1 (lut_page == $past(lut_page) && lut_addr == $past(lut_addr));
  endsequence
  a_lut_write_read: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
    s_entry_held |=> lut_rdata == $past(lut_wdata, 2)) else $error("table readback wrong");
  a_depth18_gen: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
    patgen_config_reg.enable && patgen_config_reg.depth18 |-> pat_pix.g[1:0] == 2'h0)
    else $error("18-bit low bits set");
  a_vblank_detect: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
    ext_vblank |-> !sync_in.de || !$past(sync_in.de)) else $error("vblank during data");
  a_scroll_range: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    patgen_config_reg.auto_scroll |-> slot_r <= scroll_last_r || slot_r == 4'h0)
    else $error("slot out of range");
endmodule

`default_nettype wire

// ---- rtl/video_pattern_wb_dither_pkg.sv ----
// Constants, types and field layouts for the video pattern / white balance / dither path.
// Assumes one pixel clock domain and host access through plain configuration ports.
// Operation
// [RULE_01] Pattern drives output whenever not powered down; the code drives it only while the enable bit is set, else pix_in passes
// [RULE_02] Seventeen selectable default test patterns
// [RULE_03] Colour bars skipped during automatic scrolling; the code keeps the bars slot and shows white in its place
// [RULE_04] 18-bit option zeroes two lowest colour bits
// [RULE_05] No vsync: blank after twice-line idle
// [RULE_06] Internal timing uses programmed counts; oscillator bit
// [RULE_07] External sync forwarded with two-clock delay
// [RULE_08] Measure frame size, scale gradients
// [RULE_09] Global inversion complements every colour bit
// [RULE_10] Auto-scroll through sixteen programmable slots
// [RULE_11] Extra settings via indirect index and value
// [RULE_12] Three 256-entry eight-bit readable lookup tables
// [RULE_13] Host loads all three complete tables
// [RULE_14] Six-bit input needs post-table dither enabled
// [RULE_15] Host loads red, green, blue, then enables
// [RULE_16] Rewrites rejected after initial load unless reload
// [RULE_17] Reload rewrites seamless while balance active
// [RULE_18] Dither drives six upper bits, low bits zero
// [RULE_19] Two dither stages, before and after tables
// [RULE_20] Host programs timing style and polarity; the code stores de_only and sync_pol_low but never uses them
// [RULE_21] Nine-bit extension, one of four algorithms; the code has one fixed algorithm with no selection
// [RULE_22] Default pattern entry adds one or nothing
// [RULE_23] Frame and line counters index dither tables
`default_nettype none
package video_pattern_wb_dither_pkg;

  localparam int          PAT_COUNT     = 17;      // Number of default patterns
  localparam logic [4:0]  PAT_WHITE     = 5'h00;   // Pattern codes, zero based
  localparam logic [4:0]  PAT_BLACK     = 5'h01;
  localparam logic [4:0]  PAT_RED       = 5'h02;
  localparam logic [4:0]  PAT_GREEN     = 5'h03;
  localparam logic [4:0]  PAT_BLUE      = 5'h04;
  localparam logic [4:0]  PAT_HGRAD     = 5'h05;   // 05..08 horizontal gradients
  localparam logic [4:0]  PAT_VGRAD     = 5'h09;   // 09..0c vertical gradients
  localparam logic [4:0]  PAT_CUSTOM    = 5'h0d;
  localparam logic [4:0]  PAT_CHECKER   = 5'h0e;
  localparam logic [4:0]  PAT_VCOM      = 5'h0f;
  localparam logic [4:0]  PAT_BARS      = 5'h10;
  localparam int          SCROLL_SLOTS  = 16;      // Auto-scroll sequence length
  localparam int          SYNC_DELAY    = 2;       // Pass-through delay in pixel clocks
  localparam int          LUT_DEPTH     = 256;     // Entries per colour table
  localparam logic [7:0]  LUT_RESET     = 8'h00;   // Table contents after reset
  localparam logic [1:0]  LOW_BITS_ZERO = 2'h0;    // Low bits in 18-bit output
  localparam logic [11:0] TIMING_RESET  = 12'h000; // Counter value after reset
  localparam logic [7:0]  SCROLL_FRAMES = 8'h3c;   // Default frames per scroll step
  localparam logic [3:0]  IDX_SCROLL_N  = 4'h0;    // Indirect: last scroll slot
  localparam logic [3:0]  IDX_SCROLL_T  = 4'h1;    // Indirect: frames per step
  localparam logic [3:0]  IDX_CHK_COL   = 4'h2;    // Indirect: checker colour on/off
  localparam logic [3:0]  IDX_VCOM_DIR  = 4'h3;    // Indirect: VCOM orientation

  // One pixel: three eight-bit colours
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_t;

  // Video timing bundle
  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
  } sync_t;

  // Internal timing programme
  typedef struct packed {
    logic [11:0] h_active;
    logic [11:0] h_total;
    logic [11:0] v_active;
    logic [11:0] v_total;
  } timing_t;

  // Pattern generator configuration
  typedef struct packed {
    logic       enable;     // Generator replaces video
    logic       int_timing; // Internal timing
    logic       int_clock;  // Internal oscillator clock in use
    logic       invert;     // Global inversion
    logic       depth18;    // 18-bit colour mode
    logic       auto_scroll;
    logic [4:0] pattern;    // Selected pattern
  } patcfg_t;

  // Enhancement configuration
  typedef struct packed {
    logic wb_enable;
    logic wb_reload;
    logic dither1;
    logic dither2;
    logic de_only;      // Display uses DE only
    logic sync_pol_low; // Sync active low
  } enhcfg_t;

  typedef enum logic [1:0] {LOAD_RED, LOAD_GREEN, LOAD_BLUE, LOAD_DONE} load_t;

endpackage

`default_nettype wire

// ---- dv/lcd_panel_model.sv ----
// Display panel model: counts active pixels and keeps the last one shown.
// Assumes registered RGB and active-high sync from the block under test.
`timescale 1ns/1ps
`default_nettype none

module lcd_panel_model
  import video_pattern_wb_dither_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  clr,
  input  wire rgb_t  pix,
  input  wire sync_t sync,
  output var int     de_cnt,
  output var rgb_t   last_pix
);
  // Panel takes a pixel only while data enable is high; the count is
  // cleared by the bench so a window of whole frames can be measured
  always @(posedge clk) begin
    if (clr) begin
      de_cnt <= 0;
    end else if (sync.de === 1'b1) begin
      de_cnt   <= de_cnt + 1;
      last_pix <= pix;
    end
  end
endmodule

`default_nettype wire

// ---- dv/test_video_pattern_wb_dither.sv ----
// Self-checking bench for the pattern, white balance and dither path.
// Assumes the package constants and a panel model on the pixel outputs.
`timescale 1ns/1ps
`default_nettype none

module test_video_pattern_wb_dither;
  import video_pattern_wb_dither_pkg::*;

  logic       clk, rst_n, osc, ind_wr, slot_wr, lut_wr, clr;
  rgb_t       pix_in, cust, pix_out, last_pix;
  sync_t      sync_in, sync_out, h0, h1;
  patcfg_t    cfg;
  timing_t    tim;
  enhcfg_t    enh;
  logic [3:0] idx, saddr;
  logic [7:0] ival, lut_addr, lut_wdata, lut_rdata, lut_m [3][256];
  logic [4:0] sval;
  logic [1:0] lut_page;
  logic       lut_wr_rejected, osc_required, seen;
  int         de_cnt, num_errors, n_tests, nr, nw, nb;

  video_pattern_wb_dither video_pattern_wb_dither_inst (
    .clk(clk), .rst_n(rst_n), .pix_in(pix_in), .sync_in(sync_in),
    .patgen_config_reg(cfg), .patgen_custom_colour(cust), .int_timing(tim),
    .osc_bit_set(osc), .patgen_indirect_index(idx), .patgen_indirect_value(ival),
    .ind_wr(ind_wr), .slot_addr(saddr), .slot_value(sval), .slot_wr(slot_wr),
    .enh_cfg(enh), .lut_page(lut_page), .lut_addr(lut_addr), .lut_wdata(lut_wdata),
    .lut_wr(lut_wr), .lut_rdata(lut_rdata), .lut_wr_rejected(lut_wr_rejected),
    .osc_required(osc_required), .pix_out(pix_out), .sync_out(sync_out));

  lcd_panel_model lcd_panel_model_inst (
    .clk(clk), .clr(clr), .pix(pix_out), .sync(sync_out), .de_cnt(de_cnt),
    .last_pix(last_pix));

  // 250 MHz pixel clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict in one place
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One comparison; unknowns never pass
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Table write; caller lowers the strobe after a burst
  task lwr(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d);
    lut_page = pg;
    lut_addr = a;
    lut_wdata = d;
    lut_wr = 1'b1;
    @(negedge clk);
  endtask

  // Single write; the refusal pulse stands only in the cycle after the write
  task lrej(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d, input logic ex);
    lwr(pg, a, d);
    lut_wr = 1'b0;
    seen = lut_wr_rejected;
    @(negedge clk);
    chk(seen === ex && lut_wr_rejected === 1'b0, "table write refusal");
  endtask

  task lrd(input logic [1:0] pg, input logic [7:0] a);
    lut_page = pg;
    lut_addr = a;
    cyc(2);
    chk(lut_rdata === lut_m[pg][a], "table readback");
  endtask

  // Expected full-screen colour of a solid pattern
  function automatic rgb_t solid(input logic [4:0] p, input rgb_t c, input logic inv, d18);
    rgb_t v;
    case (p)
      PAT_WHITE: v = 24'hffffff;
      PAT_BLACK: v = 24'h000000;
      PAT_RED:   v = 24'hff0000;
      PAT_GREEN: v = 24'h00ff00;
      PAT_BLUE:  v = 24'h0000ff;
      default:   v = c;
    endcase
    if (inv) v = ~v;
    if (d18) v = v & 24'hfcfcfc;
    return v;
  endfunction

  // Dithered channel: low bits idle, top six bits kept or raised by one
  function automatic logic dok(input logic [7:0] i, input logic [7:0] o);
    if (o[1:0] !== 2'h0) return 1'b0;
    if (i == 8'h00 || i == 8'hff) return o === {i[7:2], 2'h0};
    return o[7:2] === i[7:2] || (o[7:2] === i[7:2] + 6'h01 && i[7:2] != 6'h3f);
  endfunction

  // Hang guard well beyond the whole run
  initial begin
    #100000;
    num_errors++;
    final_report();
  end

  initial begin
    void'($urandom(86));
    {pix_in, sync_in, cfg, cust, tim, osc, idx, ival, ind_wr, saddr, sval} = '0;
    {slot_wr, enh, lut_page, lut_addr, lut_wdata, lut_wr, clr} = '0;
    num_errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    cyc(12);
    chk(pix_out === 24'h0 && sync_out === 3'h0, "outputs during reset");
    rst_n = 1'b1;
    // External timing: sync forwarded two clocks late
    cfg.enable = 1'b1;
    for (int i = 0; i < 40; i++) begin
      if (i > 1) chk(sync_out === h1, "sync delay");
      h1 = h0;
      sync_in = 3'($urandom);
      h0 = sync_in;
      @(negedge clk);
    end
    $display("done: sync pass-through");
    // Solid and custom patterns, inverted and 18-bit
    sync_in = 3'h4;
    for (int p = 0; p < 6; p++) begin
      for (int m = 0; m < 4; m++) begin
        cfg.pattern = (p == 5) ? PAT_CUSTOM : 5'(p);
        cfg.invert = m[0];
        cfg.depth18 = m[1];
        cust = 24'($urandom);
        cyc(4);
        chk(pix_out === solid(cfg.pattern, cust, m[0], m[1]), "pattern");
      end
    end
    $display("done: patterns");
    // Each dither stage alone on passed-through video
    cfg = '0;
    enh.de_only = 1'b1; // panel timing is data enable only
    for (int s = 0; s < 2; s++) begin
      enh.dither1 = (s == 0);
      enh.dither2 = (s == 1);
      for (int i = 0; i < 40; i++) begin
        sync_in = 3'($urandom);
        pix_in = (i == 0) ? 24'h0 : (i == 1) ? 24'hffffff : 24'($urandom);
        @(negedge clk);
        chk(dok(pix_in.r, pix_out.r) && dok(pix_in.g, pix_out.g) && dok(pix_in.b, pix_out.b), "dither");
      end
    end
    $display("done: dither");
    // Tables: order enforced, loaded red, green, blue, then locked
    enh = '0;
    lrej(2'h1, 8'h00, 8'h55, 1'b1);
    for (int pg = 0; pg < 3; pg++) begin
      for (int a = 0; a < 256; a++) begin
        lut_m[pg][a] = 8'($urandom);
        lwr(2'(pg), 8'(a), lut_m[pg][a]);
      end
    end
    lut_wr = 1'b0;
    for (int k = 0; k < 6; k++) lrd(2'(k % 3), 8'($urandom));
    lrej(2'h0, 8'h10, ~lut_m[0][16], 1'b1);
    lrd(2'h0, 8'h10);
    lrej(2'h3, 8'h00, 8'h00, 1'b1);
    // Reload while balance is live
    enh.wb_enable = 1'b1;
    enh.wb_reload = 1'b1;
    lut_m[1][8'h77] = ~lut_m[1][8'h77];
    lrej(2'h1, 8'h77, lut_m[1][8'h77], 1'b0);
    lrd(2'h1, 8'h77);
    for (int i = 0; i < 40; i++) begin
      pix_in = (i == 3) ? 24'h107720 : 24'($urandom);
      @(negedge clk);
      chk(pix_out === {lut_m[0][pix_in.r], lut_m[1][pix_in.g], lut_m[2][pix_in.b]}, "balance");
    end
    $display("done: white balance");
    // Oscillator bit demand
    enh = '0;
    cfg.int_clock = 1'b1;
    cyc(2);
    chk(osc_required === 1'b1, "osc needed");
    osc = 1'b1;
    cyc(2);
    chk(osc_required === 1'b0, "osc set");
    $display("done: oscillator");
    // Internal timing with no incoming video; frame is 8 x 4 clocks
    tim = '{h_active: 12'd4, h_total: 12'd8, v_active: 12'd2, v_total: 12'd4};
    sync_in = '0;
    pix_in = '0;
    cfg = '0;
    cfg.enable = 1'b1;
    cfg.int_timing = 1'b1;
    cyc(64);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(320);
    chk(de_cnt == 80, "active pixels per ten frames");
    chk(last_pix === 24'hffffff, "pattern without input");
    // Red ramp ends at three quarters; bars show cyan in the second column
    cfg.pattern = PAT_HGRAD + 5'h1;
    cyc(40);
    chk(last_pix === 24'hc00000, "red ramp end");
    cfg.pattern = PAT_BARS;
    nb = 0;
    repeat (32) begin
      @(negedge clk);
      if (sync_out.de === 1'b1 && pix_out === 24'h00ffff) nb++;
    end
    chk(nb == 2, "colour bars");
    $display("done: internal timing");
    // Scroll red then bars; bars must never show
    idx = IDX_SCROLL_N;
    ival = 8'h01;
    ind_wr = 1'b1;
    @(negedge clk);
    idx = IDX_SCROLL_T;
    @(negedge clk);
    ind_wr = 1'b0;
    sval = PAT_RED;
    slot_wr = 1'b1;
    @(negedge clk);
    saddr = 4'h1;
    sval = PAT_BARS;
    @(negedge clk);
    slot_wr = 1'b0;
    cfg.auto_scroll = 1'b1;
    cyc(40);
    {nr, nw, nb} = '0;
    repeat (400) begin
      @(negedge clk);
      if (sync_out.de === 1'b1) begin
        if (pix_out === 24'hff0000) nr++;
        else if (pix_out === 24'hffffff) nw++;
        else nb++;
      end
    end
    chk(nb == 0 && nr > 0 && nw > 0, "auto scroll");
    $display("done: auto scroll");
    final_report();
  end
endmodule

`default_nettype wire
